// ### core/efm_top.sv
/*
  External fault group monitor: four function-block fault groups fed by selected
  binary network signals, and two control word low-time watchdogs.
  Assumes all inputs synchronous to clock; the acknowledge is a level or pulse from control.
*/
`timescale 1ns/1ps
`include "efm_regs.svh"

module efm_top #(
  parameter int TICK_CYCLES = `EFM_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire efm_pkg::efm_net_t bin_net,
  input wire efm_pkg::efm_sel_t first_group_source_select,
  input wire efm_pkg::efm_sel_t second_group_source_select,
  input wire logic [15:0] ctrl_word_1,
  input wire logic [`EFM_CW2_MSB:`EFM_CW2_LSB] ctrl_word_2,
  input wire efm_pkg::efm_delay_t ext_fault_delay_time_1,
  input wire efm_pkg::efm_delay_t ext_fault_delay_time_2,
  input wire logic fault_ack,
  output logic fb_group_b_upper_fault,
  output logic fb_group_c_upper_fault,
  output logic ext_fault_one,
  output logic ext_fault_two,
  output logic fb_group_b_lower_fault,
  output logic fb_group_c_lower_fault,
  output logic [`EFM_VAL_W-1:0] fb_b_upper_value,
  output logic [`EFM_VAL_W-1:0] fb_c_upper_value,
  output logic [`EFM_VAL_W-1:0] fb_b_lower_value,
  output logic [`EFM_VAL_W-1:0] fb_c_lower_value,
  output logic fault_raised,
  output efm_pkg::efm_fault_e fault_id,
  output logic [7:0] fault_value_record,
  output efm_pkg::efm_diag_t fault_diag_buffer
);
  import efm_pkg::*;

  // lowest set entry wins; zero when none
  function automatic logic [`EFM_VAL_W-1:0] efm_prio4(input logic [3:0] v);
    if (v[0]) return 3'h1; // [RULE_09]
    else if (v[1]) return 3'h2;
    else if (v[2]) return 3'h3;
    else if (v[3]) return 3'h4;
    else return `EFM_VAL_RST;
  endfunction : efm_prio4

  // a select is as wide as the network index, so no entry can point past the network
  function automatic logic [`EFM_ENTRIES-1:0] efm_pick(input efm_net_t net, input efm_sel_t sel);
    logic [`EFM_ENTRIES-1:0] r;
    r = '0;
    for (int i = 0; i < `EFM_ENTRIES; i++) begin
      r[i] = net[sel[i]];
    end
    return r;
  endfunction : efm_pick

  // millisecond tick; parameter lets a simulation shorten it
  // free running and shared by both watchdogs: the first tick of a low phase lands 1 to
  // TICK_CYCLES cycles in, so low time is resolved to one tick, not one cycle
  logic [`EFM_TICK_W-1:0] presc_r;
  wire logic tick = (presc_r == `EFM_TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      presc_r <= '0;
    end else if (ce) begin
      presc_r <= tick ? '0 : presc_r + `EFM_TICK_W'(1);
    end
  end

  // selection is never gated by drive state
  wire logic [`EFM_ENTRIES-1:0] grp1 = efm_pick(bin_net, first_group_source_select); // [RULE_07]
  wire logic [`EFM_ENTRIES-1:0] grp2 = efm_pick(bin_net, second_group_source_select);
  wire logic [`EFM_VAL_W-1:0] enc_b_up = efm_prio4(grp1[7:4]); // [RULE_01]
  wire logic [`EFM_VAL_W-1:0] enc_c_up = efm_prio4(grp2[7:4]); // [RULE_02]
  wire logic [`EFM_VAL_W-1:0] enc_b_lo = efm_prio4(grp1[3:0]); // [RULE_03]
  wire logic [`EFM_VAL_W-1:0] enc_c_lo = efm_prio4(grp2[3:0]); // [RULE_04]

  logic exp1;
  logic exp2;
  efm_delay_t low1;
  efm_delay_t low2;

  efm_lowtime u_low1 (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .tick(tick),
    .watched_bit(ctrl_word_1[`EFM_CW1_BIT]),
    .delay_limit(ext_fault_delay_time_1),
    .expired(exp1),
    .low_count(low1)
  ); // [RULE_05]

  efm_lowtime u_low2 (
    .clock(clock),
    .rstn(rstn),
    .ce(ce),
    .tick(tick),
    .watched_bit(ctrl_word_2[`EFM_CW2_BIT]),
    .delay_limit(ext_fault_delay_time_2),
    .expired(exp2),
    .low_count(low2)
  ); // [RULE_06]

  // a group is active when its encoder finds any selected signal at one
  wire logic hit_b_up = (enc_b_up != `EFM_VAL_RST);
  wire logic hit_c_up = (enc_c_up != `EFM_VAL_RST);
  wire logic hit_b_lo = (enc_b_lo != `EFM_VAL_RST);
  wire logic hit_c_lo = (enc_c_lo != `EFM_VAL_RST);

  // order: b_upper, c_upper, ext1, ext2, b_lower, c_lower
  wire logic [`EFM_NUM_FAULTS-1:0] cond = {hit_c_lo, hit_b_lo, exp2, exp1, hit_c_up, hit_b_up};
  logic [`EFM_NUM_FAULTS-1:0] fault_r;
  wire logic [`EFM_NUM_FAULTS-1:0] ack_mask = {`EFM_NUM_FAULTS{fault_ack}};
  // a live condition during acknowledge keeps the flag set
  wire logic [`EFM_NUM_FAULTS-1:0] held = fault_r & ~ack_mask;
  wire logic [`EFM_NUM_FAULTS-1:0] fault_nxt = cond | held; // [RULE_10]
  // only a flag not yet latched is new: a held acknowledge must not record a cause again
  wire logic [`EFM_NUM_FAULTS-1:0] rise = cond & ~fault_r;

  assign fb_group_b_upper_fault = fault_r[0];
  assign fb_group_c_upper_fault = fault_r[1];
  assign ext_fault_one = fault_r[2];
  assign ext_fault_two = fault_r[3];
  assign fb_group_b_lower_fault = fault_r[4];
  assign fb_group_c_lower_fault = fault_r[5];

  // first new fault in output order is the one recorded when several rise together
  wire efm_fault_e id_nxt = rise[0] ? EFM_FB_B_UPPER : rise[1] ? EFM_FB_C_UPPER :
                            rise[2] ? EFM_EXT_ONE : rise[3] ? EFM_EXT_TWO :
                            rise[4] ? EFM_FB_B_LOWER : EFM_FB_C_LOWER;
  wire logic [7:0] rec_nxt = rise[0] ? {5'h00, enc_b_up} : rise[1] ? {5'h00, enc_c_up} :
                             (rise[2] | rise[3]) ? `EFM_EXT_VALUE :
                             rise[4] ? {5'h00, enc_b_lo} : {5'h00, enc_c_lo};
  wire logic any_rise = |rise;

  // entry 2 holds the selected signal states, entry 3 the low-time count of the external fault raised, rest zero
  efm_diag_t diag_nxt;
  always_comb begin
    diag_nxt = '0;
    if (rise[2] | rise[3]) begin
      diag_nxt[0] = {grp2, grp1};
      diag_nxt[1] = rise[2] ? low1 : low2;
    end else begin
      diag_nxt[0] = {grp2, grp1};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_r <= '0;
    end else if (ce) begin
      fault_r <= fault_nxt;
    end
  end

  // high for one cycle after each cycle that takes any new cause; causes taken together share one pulse
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_raised <= 1'b0;
    end else if (ce) begin
      fault_raised <= any_rise;
    end
  end

  // a value is frozen while its fault stays latched and is not being acknowledged, so the first cause stays visible
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb_b_upper_value <= `EFM_VAL_RST;
    end else if (ce) begin
      fb_b_upper_value <= held[0] ? fb_b_upper_value : enc_b_up; // [RULE_08]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb_c_upper_value <= `EFM_VAL_RST;
    end else if (ce) begin
      fb_c_upper_value <= held[1] ? fb_c_upper_value : enc_c_up;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb_b_lower_value <= `EFM_VAL_RST;
    end else if (ce) begin
      fb_b_lower_value <= held[4] ? fb_b_lower_value : enc_b_lo;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb_c_lower_value <= `EFM_VAL_RST;
    end else if (ce) begin
      fb_c_lower_value <= held[5] ? fb_c_lower_value : enc_c_lo;
    end
  end

  // acknowledge leaves the record alone, so the cause can still be read after clearing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_id <= EFM_NONE;
    end else if (ce && any_rise) begin
      fault_id <= id_nxt; // [RULE_08]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_value_record <= 8'h00;
    end else if (ce && any_rise) begin
      fault_value_record <= rec_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_diag_buffer <= '0;
    end else if (ce && any_rise) begin
      fault_diag_buffer <= diag_nxt;
    end
  end
endmodule : efm_top

// ### core/efm_regs.svh
/*
  Constants of the external fault monitor: field positions, widths, reset values and timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Summary of operation
// RULE_01 - upper first-group entries one raise group B fault
// RULE_02 - upper second-group entries one raise group C fault
// RULE_03 - lower first-group entries one raise group B fault
// RULE_04 - lower second-group entries one raise group C fault
// RULE_05 - word one bit 15 low too long
// RULE_06 - word two bit 26 low too long
// RULE_07 - monitors armed in every operating state
// RULE_08 - raised fault stores value and diagnostics
// RULE_09 - simultaneous signals report the lowest entry
// RULE_10 - faults latch until acknowledge; counters restart
`ifndef EFM_REGS_SVH
`define EFM_REGS_SVH

`define EFM_NET_W 256
`define EFM_SEL_W 8
`define EFM_ENTRIES 8
`define EFM_VAL_W 3
`define EFM_DELAY_W 16
`define EFM_TICK_W 20
`define EFM_DIAG_W 16
`define EFM_DIAG_FIRST 2
`define EFM_DIAG_LAST 16
`define EFM_NUM_FAULTS 6
`define EFM_CW1_BIT 15
`define EFM_CW2_BIT 26
`define EFM_CW2_LSB 16
`define EFM_CW2_MSB 31
`define EFM_EXT_VALUE 8'h01
`define EFM_VAL_RST 3'h0
`define EFM_CNT_RST 16'h0000
`define EFM_CNT_MAX 16'hFFFF
`define EFM_TICK_TIME_NS 1000000
`define EFM_CLK_PERIOD_NS 4
`define EFM_TICK_CYCLES (`EFM_TICK_TIME_NS / `EFM_CLK_PERIOD_NS)

`endif

// ### core/efm_pkg.sv
/*
  Types shared by the external fault monitor modules.
  Assumes efm_regs.svh is on the include path.
*/
`include "efm_regs.svh"

package efm_pkg;
  typedef logic [`EFM_SEL_W-1:0] efm_idx_t;
  typedef logic [`EFM_ENTRIES-1:0][`EFM_SEL_W-1:0] efm_sel_t;
  typedef logic [`EFM_NET_W-1:0] efm_net_t;
  typedef logic [`EFM_DELAY_W-1:0] efm_delay_t;
  typedef logic [`EFM_DIAG_LAST-`EFM_DIAG_FIRST:0][`EFM_DIAG_W-1:0] efm_diag_t;
  // fault identity reported with the fault value record
  typedef enum logic [2:0] {
    EFM_NONE = 3'h0,
    EFM_FB_B_UPPER = 3'h1,
    EFM_FB_C_UPPER = 3'h3,
    EFM_EXT_ONE = 3'h2,
    EFM_EXT_TWO = 3'h6,
    EFM_FB_B_LOWER = 3'h7,
    EFM_FB_C_LOWER = 3'h5
  } efm_fault_e;
endpackage : efm_pkg

// ### core/efm_lowtime.sv
/*
  Low-time watchdog for one control word bit, counting in millisecond ticks.
  Assumes a one-cycle tick from the parent and inputs synchronous to clock.
*/
`timescale 1ns/1ps
`include "efm_regs.svh"

module efm_lowtime (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tick,
  input wire logic watched_bit,
  input wire efm_pkg::efm_delay_t delay_limit,
  output logic expired,
  output efm_pkg::efm_delay_t low_count
);
  import efm_pkg::*;

  efm_delay_t count_r;
  efm_delay_t count_nxt;
  wire logic at_max = (count_r == `EFM_CNT_MAX);

  // restart on any high sample, saturate so a long low never wraps back under the limit
  assign count_nxt = watched_bit ? `EFM_CNT_RST :
                     (tick && !at_max) ? count_r + 16'h0001 : count_r; // [RULE_10]

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_r <= `EFM_CNT_RST;
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end

  // strictly longer than the limit
  assign expired = !watched_bit && (count_r > delay_limit); // [RULE_05] [RULE_06]
  assign low_count = count_r;
endmodule : efm_lowtime

// ### verification/efm_src_model.sv
/* far-side model: binary signal network and the two control words.
   assumes the bench moves its controls just after the rising edge */
`timescale 1ns/1ps
module efm_src_model (
  input wire logic ra,
  input wire logic rb,
  input wire efm_pkg::efm_idx_t ia,
  input wire efm_pkg::efm_idx_t ib,
  input wire logic l1,
  input wire logic l2,
  output efm_pkg::efm_net_t bin_net,
  output logic [15:0] ctrl_word_1,
  output logic [31:16] ctrl_word_2
);
  import efm_pkg::*;
  assign bin_net = (efm_net_t'(ra) << ia) | (efm_net_t'(rb) << ib);
  // unwatched bits carry a pattern so a wrong bit pick shows up
  assign ctrl_word_1 = {~l1, 15'h2AAA};
  assign ctrl_word_2 = {5'h15, ~l2, 10'h2AA};
endmodule : efm_src_model

// ### verification/efm_top_sva.sv
/* port checker for efm_top.
   assumes bind into efm_top, one clock domain */
`timescale 1ns/1ps
module efm_top_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire efm_pkg::efm_net_t bin_net,
  input wire efm_pkg::efm_sel_t first_group_source_select,
  input wire efm_pkg::efm_sel_t second_group_source_select,
  input wire logic [15:0] ctrl_word_1,
  input wire logic [31:16] ctrl_word_2,
  input wire logic fault_ack,
  input wire logic fb_group_b_upper_fault,
  input wire logic fb_group_c_upper_fault,
  input wire logic ext_fault_one,
  input wire logic ext_fault_two,
  input wire logic fb_group_b_lower_fault,
  input wire logic fb_group_c_lower_fault,
  input wire logic [2:0] fb_b_upper_value,
  input wire logic fault_raised,
  input wire logic [7:0] fault_value_record
);
  import efm_pkg::*;
  function automatic logic any4(efm_sel_t s, int b, efm_net_t n);
    any4 = n[s[b]] | n[s[b+1]] | n[s[b+2]] | n[s[b+3]];
  endfunction : any4
  wire bu = any4(first_group_source_select, 4, bin_net);
  wire cu = any4(second_group_source_select, 4, bin_net);
  wire bl = any4(first_group_source_select, 0, bin_net);
  wire cl = any4(second_group_source_select, 0, bin_net);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_b_upper_set: assert property (ce && bu |=> fb_group_b_upper_fault)
    else $error("group b upper fault missing");
  a_c_upper_set: assert property (ce && cu |=> fb_group_c_upper_fault)
    else $error("group c upper fault missing");
  a_b_lower_set: assert property (ce && bl |=> fb_group_b_lower_fault)
    else $error("group b lower fault missing");
  a_c_lower_set: assert property (ce && cl |=> fb_group_c_lower_fault)
    else $error("group c lower fault missing");
  a_ext_one_low: assert property ($rose(ext_fault_one) |-> !$past(ctrl_word_1[15]))
    else $error("external fault one without low bit");
  a_ext_two_low: assert property ($rose(ext_fault_two) |-> !$past(ctrl_word_2[26]))
    else $error("external fault two without low bit");
  a_fault_latch_hold: assert property (
    fb_group_b_lower_fault && !fault_ack |=> fb_group_b_lower_fault)
    else $error("fault dropped without acknowledge");
  a_raise_report: assert property (
    $rose(fb_group_b_upper_fault) |->
    fault_raised && fault_value_record == {5'h00, fb_b_upper_value})
    else $error("raised fault not recorded");
  a_lowest_entry: assert property (
    ce && !fb_group_b_upper_fault && bin_net[first_group_source_select[4]] |=>
    fb_b_upper_value == 3'h1)
    else $error("lowest entry not reported");
  a_ce_freeze: assert property (
    !ce |=> $stable({fb_group_b_upper_fault, fb_group_c_upper_fault, ext_fault_one,
    ext_fault_two, fb_group_b_lower_fault, fb_group_c_lower_fault, fault_raised,
    fault_value_record}))
    else $error("state moved while clock enable low");
  c_raised: cover property (fault_raised);
  c_ext_one: cover property ($rose(ext_fault_one));
  c_ext_two: cover property ($rose(ext_fault_two));
endmodule : efm_top_sva
bind efm_top efm_top_sva u_sva (.clock, .rstn, .ce, .bin_net, .first_group_source_select,
  .second_group_source_select, .ctrl_word_1, .ctrl_word_2, .fault_ack,
  .fb_group_b_upper_fault, .fb_group_c_upper_fault, .ext_fault_one, .ext_fault_two,
  .fb_group_b_lower_fault, .fb_group_c_lower_fault, .fb_b_upper_value, .fault_raised,
  .fault_value_record);

// ### verification/test_efm_top.sv
/* bench for efm_top: selected-signal fault groups and low-time watchdogs.
   assumes efm_src_model drives the network and control words */
`timescale 1ns/1ps
module test_efm_top;
  import efm_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, ce = 1'b1, fault_ack = 1'b0;
  logic ra = 1'b0, rb = 1'b0, l1 = 1'b0, l2 = 1'b0;
  efm_idx_t ia = 8'h00, ib = 8'h00;
  efm_delay_t lim = 16'h0002;
  efm_sel_t first_group_source_select, second_group_source_select;
  efm_net_t bin_net;
  efm_diag_t fault_diag_buffer;
  logic [15:0] ctrl_word_1;
  logic [31:16] ctrl_word_2;
  logic fb_group_b_upper_fault, fb_group_c_upper_fault, fb_group_b_lower_fault;
  logic fb_group_c_lower_fault, ext_fault_one, ext_fault_two, fault_raised;
  logic [2:0] fb_b_upper_value, fb_c_upper_value, fb_b_lower_value, fb_c_lower_value;
  logic [7:0] fault_value_record;
  efm_fault_e fault_id;
  int error_cnt = 0, n_checks = 0;
  wire [3:0] fl = {fb_group_b_upper_fault, fb_group_c_upper_fault, fb_group_b_lower_fault,
    fb_group_c_lower_fault};
  always #2 clock = ~clock;
  initial for (int i = 0; i < 8; i++) begin
    first_group_source_select[i] = 8'(i);
    second_group_source_select[i] = 8'(8'h10 + i);
  end
  // short prescaler keeps the low-time runs to tens of cycles
  efm_top #(.TICK_CYCLES(4)) DUT (.clock, .rstn, .ce, .bin_net, .first_group_source_select,
    .second_group_source_select, .ctrl_word_1, .ctrl_word_2, .ext_fault_delay_time_1(lim),
    .ext_fault_delay_time_2(lim), .fault_ack, .fb_group_b_upper_fault, .fb_group_c_upper_fault,
    .ext_fault_one, .ext_fault_two, .fb_group_b_lower_fault, .fb_group_c_lower_fault,
    .fb_b_upper_value, .fb_c_upper_value, .fb_b_lower_value, .fb_c_lower_value,
    .fault_raised, .fault_id, .fault_value_record, .fault_diag_buffer);
  efm_src_model u_src (.ra, .rb, .ia, .ib, .l1, .l2, .bin_net, .ctrl_word_1, .ctrl_word_2);
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic clr();
    @(posedge clock);
    ra <= 1'b0;
    rb <= 1'b0;
    l1 <= 1'b0;
    l2 <= 1'b0;
    fault_ack <= 1'b1;
    repeat (2) @(posedge clock);
    fault_ack <= 1'b0;
    cyc(1);
  endtask : clr
  task automatic t_groups();
    for (int e = 0; e < 8; e++) begin
      for (int g = 0; g < 2; g++) begin
        @(posedge clock);
        ia <= g ? 8'(8'h10 + e) : 8'(e);
        ra <= 1'b1;
        cyc(1);
        chk("flags", fl, 4'b1000 >> (g + 2 * (e < 4)));
        chk("id", fault_id, g ? (e < 4 ? EFM_FB_C_LOWER : EFM_FB_C_UPPER)
          : (e < 4 ? EFM_FB_B_LOWER : EFM_FB_B_UPPER));
        chk("value", g ? (e < 4 ? fb_c_lower_value : fb_c_upper_value)
          : (e < 4 ? fb_b_lower_value : fb_b_upper_value), e % 4 + 1);
        chk("record", {fault_raised, fault_value_record}, {1'b1, 8'(e % 4 + 1)});
        clr();
      end
    end
  endtask : t_groups
  task automatic t_lowest();
    @(posedge clock);
    ia <= 8'h06;
    ib <= 8'h05;
    ra <= 1'b1;
    rb <= 1'b1;
    cyc(1);
    chk("lowest", fb_b_upper_value, 3'h2);
    chk("diag", fault_diag_buffer[0], 16'h0060);
    @(posedge clock);
    ia <= 8'h04;
    cyc(2);
    chk("frozen", fb_b_upper_value, 3'h2);
    clr();
  endtask : t_lowest
  task automatic t_ce();
    @(posedge clock);
    ce <= 1'b0;
    ia <= 8'h04;
    ra <= 1'b1;
    cyc(3);
    chk("ce frozen", {fl, fault_raised}, 5'h00);
    @(posedge clock);
    ce <= 1'b1;
    cyc(1);
    chk("ce resumed", {fl, fault_raised, fb_b_upper_value}, {4'h8, 1'b1, 3'h1});
    cyc(1);
    chk("pulse", {fl, fault_raised}, {4'h8, 1'b0});
    clr();
  endtask : t_ce
  task automatic t_ext();
    for (int k = 0; k < 2; k++) begin
      // two short lows split by a high: only a restarting count stays under the limit
      for (int r = 0; r < 3; r++) begin
        @(posedge clock);
        l1 <= k == 0 && r != 1;
        l2 <= k == 1 && r != 1;
        cyc(r == 1 ? 2 : 6);
      end
      chk("early", {ext_fault_two, ext_fault_one}, 2'b00);
      for (int t = 0; t < 20 && !(ext_fault_one | ext_fault_two); t++) cyc(1);
      chk("ext", {ext_fault_two, ext_fault_one}, {k == 1, k == 0});
      chk("ext record", fault_value_record, 8'h01);
      chk("ext id", fault_id, k ? EFM_EXT_TWO : EFM_EXT_ONE);
      chk("ext diag", fault_diag_buffer[1], lim + 16'h0001);
      @(posedge clock);
      l1 <= 1'b0;
      l2 <= 1'b0;
      cyc(3);
      chk("latched", {ext_fault_two, ext_fault_one}, {k == 1, k == 0});
      clr();
      chk("cleared", {ext_fault_two, ext_fault_one}, 2'b00);
    end
  endtask : t_ext
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_groups();
    t_lowest();
    t_ce();
    t_ext();
    complete_run();
  end
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule : test_efm_top
